/* File: hdl/rtc_pkg.sv */
// Constants, types and field layouts shared by the BCD clock/calendar core.
// Overview of operation
// RL1 - Wave disabled: pin shows static level bit
// RL2 - Wave enabled: pin carries selected square wave
// RL3 - Rate bits pick 1Hz/4k/8k/32k, default 32k
// RL4 - 1 Hz: time advances on falling edge
// RL5 - Any oscillator stop sets stop flag
// RL6 - Stop flag clears only by writing zero
// RL7 - Seconds count 00-59, carry into minutes
// RL8 - Minutes count 00-59, carry into hours
// RL9 - Hour rollover carries into date and weekday
// RL10 - Hours bit 6 selects 12/24 hour mode
// RL11 - 12-hour byte: bit6 set, bit5 PM
// RL12 - Host sets hour mode before writing time
// RL13 - Weekday counts 01 to 07, back to 01
// RL14 - Date length follows month and leap year
// RL15 - Month counts 1-12, carry into year
// RL16 - Year 00-99, multiples of four leap
// RL17 - Bus lines released high when idle
// RL18 - Start/stop only as data edges, clock high
// RL19 - Data changes clock low, sampled clock high
// RL20 - Respond only to own slave address
// RL21 - Lines driven low or released only
// RL22 - Seven-bit address 1101000 plus direction bit
// RL23 - Pointer increments after every data byte
// RL24 - Only six pointer bits are decoded
// RL25 - Second tick divides oscillator by 32768
// RL26 - Fixed-zero bits read zero, ignore writes
package rtc_pkg;
	// System clock period
	localparam int CLK_PERIOD_NS = 10;
	// Silence on the oscillator pin that counts as stopped
	localparam int OSC_STOP_NS = 100000;
	// Least time, rounded up to whole cycles
	localparam int OSC_STOP_CYC = (OSC_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Bus slave address
	localparam logic [6:0] SLAVE_ADDR = 7'h68;
	// Register pointer offsets
	localparam logic [5:0] REG_SEC = 6'h00;
	localparam logic [5:0] REG_MIN = 6'h01;
	localparam logic [5:0] REG_HOUR = 6'h02;
	localparam logic [5:0] REG_WDAY = 6'h03;
	localparam logic [5:0] REG_DATE = 6'h04;
	localparam logic [5:0] REG_MONTH = 6'h05;
	localparam logic [5:0] REG_YEAR = 6'h06;
	localparam logic [5:0] REG_CTL = 6'h07;
	// Field positions
	localparam int BIT_OSCILLATOR_DISABLE = 7;
	localparam int BIT_OUT = 7;
	localparam int BIT_OSF = 5;
	localparam int BIT_SQUARE_WAVE_ENABLE = 4;
	localparam int BIT_H12 = 6;
	localparam int BIT_PM = 5;
	// Prescaler layout: taps for each divided rate
	localparam int DIV_W = 15;
	localparam logic [14:0] DIV_MAX = 15'h7fff;
	localparam int TAP_8K = 1;
	localparam int TAP_4K = 2;
	localparam int TAP_1HZ = 14;
	// BCD limits
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_11 = 8'h11;
	localparam logic [7:0] BCD_01 = 8'h01;
	localparam logic [7:0] BCD_07 = 8'h07;
	localparam logic [7:0] FEB = 8'h02;
	localparam logic [7:0] BCD_28 = 8'h28;
	localparam logic [7:0] BCD_29 = 8'h29;
	localparam logic [7:0] BCD_30 = 8'h30;
	localparam logic [7:0] BCD_31 = 8'h31;
	localparam logic [7:0] BCD_99 = 8'h99;
	// Square-wave rate codes
	typedef enum logic [1:0] {
		RATE_1HZ = 2'b00,
		RATE_4K = 2'b01,
		RATE_8K = 2'b10,
		RATE_32K = 2'b11
	} rtc_rate_t;
	// Output and flag control register
	typedef struct packed {
		logic out;
		logic oscillator_stop_flag;
		logic square_wave_enable;
		rtc_rate_t rs;
	} rtc_ctl_t;
	// Time and calendar counters, fixed-zero bits left out
	typedef struct packed {
		logic oscillator_disable;
		logic [6:0] sec;
		logic [6:0] min;
		logic [6:0] hour;
		logic [2:0] wday;
		logic [5:0] date;
		logic [4:0] month;
		logic [7:0] year;
	} rtc_time_t;
	// Power-up values
	localparam rtc_ctl_t CTL_RESET = '{out: 1'b1, oscillator_stop_flag: 1'b1, square_wave_enable: 1'b1, rs: RATE_32K};
	localparam rtc_time_t TIME_RESET = '{oscillator_disable: 1'b0, sec: 7'h00, min: 7'h00,
		hour: 7'h00, wday: 3'h1, date: 6'h01, month: 5'h01, year: 8'h00};
	// Bus slave states
	typedef enum logic [2:0] {
		BS_IDLE = 3'b000,
		BS_ADDR = 3'b001,
		BS_PTR = 3'b010,
		BS_WDATA = 3'b011,
		BS_SACK = 3'b100,
		BS_RDATA = 3'b101,
		BS_MACK = 3'b110
	} rtc_bus_st_t;
endpackage : rtc_pkg

/* File: hdl/rtc_core.sv */
// Clock/calendar core with two-wire slave port and square-wave pin.
`timescale 1ns/1ps
module rtc_core #(
	parameter int OSC_STOP_CYC = rtc_pkg::OSC_STOP_CYC
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Crystal oscillator pin
	input wire logic osc_in,
	// Two-wire bus
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Square-wave or static output
	output logic wave_output_pin
);
	// Synchroniser stages, order {osc, scl, sda}
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] prev_q;
	// Prescaler and stop detector
	logic [14:0] div_q;
	logic [31:0] idle_cnt_q;
	logic osc_rise;
	logic osc_stopped;
	logic tick;
	// Registers
	rtc_pkg::rtc_time_t tm_q;
	rtc_pkg::rtc_time_t tm_d;
	rtc_pkg::rtc_ctl_t ctl_q;
	logic wave_sel;
	// Bus slave state
	rtc_pkg::rtc_bus_st_t st_q;
	rtc_pkg::rtc_bus_st_t after_ack_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [5:0] ptr_q;
	logic sda_oe_q;
	// Bus events
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic wr_en;
	logic [7:0] rd_byte;

	// Two flops on every pin, then one more stage to find edges
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			prev_q <= 3'h7;
		end else if (clk_en) begin
			sync1_q <= {osc_in, scl_i, sda_i};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Oscillator edge, blocked while the oscillator is disabled
	assign osc_rise = sync2_q[2] & ~prev_q[2] & ~tm_q.oscillator_disable;
	// Bus clock edges
	assign scl_rise = sync2_q[1] & ~prev_q[1];
	assign scl_fall = ~sync2_q[1] & prev_q[1];
	// Start and stop: data edges while clock stays high
	assign bus_start = sync2_q[1] & prev_q[1] & ~sync2_q[0] & prev_q[0]; // [RL18]
	assign bus_stop = sync2_q[1] & prev_q[1] & sync2_q[0] & ~prev_q[0]; // [RL18]

	// Divide by 32768; the top tap is the 1 Hz wave
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_q <= '0;
		end else if (clk_en && osc_rise) begin
			div_q <= div_q + 15'h0001; // [RL25]
		end
	end

	// Second tick where the 1 Hz tap falls, only on a live edge
	assign tick = osc_rise & (div_q == rtc_pkg::DIV_MAX); // [RL4] [RL25]

	// Cycles since the last oscillator edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			idle_cnt_q <= '0;
		end else if (clk_en) begin
			if (osc_rise) begin
				idle_cnt_q <= '0;
			end else if (idle_cnt_q != 32'(OSC_STOP_CYC)) begin
				idle_cnt_q <= idle_cnt_q + 32'h1;
			end
		end
	end

	// Oscillator counted as stopped after a long silence
	assign osc_stopped = (idle_cnt_q == 32'(OSC_STOP_CYC));

	// BCD increment of one byte
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_inc

	// Last date of a month; two-digit year divisible by four is leap
	function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
		logic [1:0] rem;
		rem = {yr[4], 1'b0} + yr[1:0];
		unique case (mo)
			rtc_pkg::FEB: month_len = (rem == 2'h0) ? rtc_pkg::BCD_29 : rtc_pkg::BCD_28; // [RL16]
			8'h04, 8'h06, 8'h09, 8'h11: month_len = rtc_pkg::BCD_30; // [RL14]
			default: month_len = rtc_pkg::BCD_31; // [RL14]
		endcase
	endfunction : month_len

	// Next counter values: tick first, then any bus write on top
	always_comb begin
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hr;
		logic [7:0] dt;
		logic [7:0] mo;
		logic [7:0] yr;
		logic carry;
		sec = {1'b0, tm_q.sec};
		min = {1'b0, tm_q.min};
		hr = {3'h0, tm_q.hour[4:0]};
		dt = {2'h0, tm_q.date};
		mo = {3'h0, tm_q.month};
		yr = tm_q.year;
		carry = 1'b0;
		tm_d = tm_q;
		if (tick) begin
			// Seconds
			carry = (sec == rtc_pkg::BCD_59); // [RL7]
			tm_d.sec = carry ? 7'h00 : 7'(bcd_inc(sec)); // [RL7]
			// Minutes
			if (carry) begin
				carry = (min == rtc_pkg::BCD_59); // [RL8]
				tm_d.min = carry ? 7'h00 : 7'(bcd_inc(min)); // [RL8]
			end
			// Hours in the selected format
			if (carry) begin
				if (!tm_q.hour[rtc_pkg::BIT_H12]) begin
					hr = {2'h0, tm_q.hour[5:0]};
					carry = (hr == rtc_pkg::BCD_23); // [RL9] [RL10]
					tm_d.hour = carry ? 7'h00 : 7'(bcd_inc(hr));
				end else if (hr == rtc_pkg::BCD_12) begin
					// 12 goes to 01, meridiem kept
					carry = 1'b0;
					tm_d.hour = {1'b1, tm_q.hour[rtc_pkg::BIT_PM], rtc_pkg::BCD_01[4:0]};
				end else if (hr == rtc_pkg::BCD_11) begin
					// 11 goes to 12 and flips meridiem; PM 11 ends the day
					carry = tm_q.hour[rtc_pkg::BIT_PM]; // [RL9] [RL11]
					tm_d.hour = {1'b1, ~tm_q.hour[rtc_pkg::BIT_PM], rtc_pkg::BCD_12[4:0]};
				end else begin
					carry = 1'b0;
					tm_d.hour = {tm_q.hour[6:5], 5'(bcd_inc(hr))}; // [RL11]
				end
			end
			// Day rollover feeds weekday and date
			if (carry) begin
				tm_d.wday = (tm_q.wday == rtc_pkg::BCD_07[2:0]) ? 3'h1
					: tm_q.wday + 3'h1; // [RL13]
				carry = (dt == month_len(mo, yr)); // [RL14]
				tm_d.date = carry ? 6'h01 : 6'(bcd_inc(dt));
			end
			// Month then year
			if (carry) begin
				carry = (mo == rtc_pkg::BCD_12); // [RL15]
				tm_d.month = carry ? 5'h01 : 5'(bcd_inc(mo));
			end
			if (carry) begin
				tm_d.year = (yr == rtc_pkg::BCD_99) ? 8'h00 : bcd_inc(yr); // [RL16]
			end
		end
		// Bus write overrides the addressed field; zero bits are dropped
		if (wr_en) begin
			unique case (ptr_q)
				rtc_pkg::REG_SEC: begin
					tm_d.oscillator_disable = sh_q[rtc_pkg::BIT_OSCILLATOR_DISABLE];
					tm_d.sec = sh_q[6:0];
				end
				rtc_pkg::REG_MIN: tm_d.min = sh_q[6:0]; // [RL26]
				rtc_pkg::REG_HOUR: tm_d.hour = sh_q[6:0]; // [RL10] [RL26]
				rtc_pkg::REG_WDAY: tm_d.wday = sh_q[2:0]; // [RL26]
				rtc_pkg::REG_DATE: tm_d.date = sh_q[5:0]; // [RL26]
				rtc_pkg::REG_MONTH: tm_d.month = sh_q[4:0]; // [RL26]
				rtc_pkg::REG_YEAR: tm_d.year = sh_q;
				default: tm_d.oscillator_disable = tm_q.oscillator_disable;
			endcase
		end
	end

	// Time and calendar counters
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tm_q <= rtc_pkg::TIME_RESET;
		end else if (clk_en) begin
			tm_q <= tm_d;
		end
	end

	// Control register; a stop in the clearing cycle keeps the flag set
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_q <= rtc_pkg::CTL_RESET;
		end else if (clk_en) begin
			if (wr_en && ptr_q == rtc_pkg::REG_CTL) begin
				ctl_q.out <= sh_q[rtc_pkg::BIT_OUT];
				ctl_q.square_wave_enable <= sh_q[rtc_pkg::BIT_SQUARE_WAVE_ENABLE];
				ctl_q.rs <= rtc_pkg::rtc_rate_t'(sh_q[1:0]); // [RL3]
			end
			if (tm_q.oscillator_disable || osc_stopped) begin
				ctl_q.oscillator_stop_flag <= 1'b1; // [RL5]
			end else if (wr_en && ptr_q == rtc_pkg::REG_CTL && !sh_q[rtc_pkg::BIT_OSF]) begin
				ctl_q.oscillator_stop_flag <= 1'b0; // [RL6]
			end
		end
	end

	// Wave source picked by the rate bits
	always_comb begin
		unique case (ctl_q.rs)
			rtc_pkg::RATE_1HZ: wave_sel = div_q[rtc_pkg::TAP_1HZ]; // [RL3]
			rtc_pkg::RATE_4K: wave_sel = div_q[rtc_pkg::TAP_4K]; // [RL3]
			rtc_pkg::RATE_8K: wave_sel = div_q[rtc_pkg::TAP_8K]; // [RL3]
			rtc_pkg::RATE_32K: wave_sel = sync2_q[2] & ~tm_q.oscillator_disable; // [RL3]
		endcase
	end

	// Output pin: wave when enabled, else the static level
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wave_output_pin <= 1'b1;
		end else if (clk_en) begin
			wave_output_pin <= ctl_q.square_wave_enable ? wave_sel : ctl_q.out; // [RL1] [RL2]
		end
	end

	// Read view; fixed-zero bits read zero, unmapped space reads zero
	always_comb begin
		unique case (ptr_q)
			rtc_pkg::REG_SEC: rd_byte = {tm_q.oscillator_disable, tm_q.sec};
			rtc_pkg::REG_MIN: rd_byte = {1'b0, tm_q.min}; // [RL26]
			rtc_pkg::REG_HOUR: rd_byte = {1'b0, tm_q.hour}; // [RL26]
			rtc_pkg::REG_WDAY: rd_byte = {5'h00, tm_q.wday}; // [RL26]
			rtc_pkg::REG_DATE: rd_byte = {2'h0, tm_q.date}; // [RL26]
			rtc_pkg::REG_MONTH: rd_byte = {3'h0, tm_q.month}; // [RL26]
			rtc_pkg::REG_YEAR: rd_byte = tm_q.year;
			rtc_pkg::REG_CTL: rd_byte = {ctl_q.out, 1'b0, ctl_q.oscillator_stop_flag, ctl_q.square_wave_enable, 2'h0, ctl_q.rs};
			default: rd_byte = 8'h00;
		endcase
	end

	// A full data byte at the falling clock after its eighth bit
	assign wr_en = (st_q == rtc_pkg::BS_WDATA) & scl_fall & (cnt_q == 4'h8) & ~bus_start
		& ~bus_stop;

	// Bus slave: shifts on clock rise, drives on clock fall
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= rtc_pkg::BS_IDLE;
			after_ack_q <= rtc_pkg::BS_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 6'h00;
			sda_oe_q <= 1'b0;
		end else if (clk_en) begin
			if (bus_start) begin
				// Start or restart: take a new address byte
				st_q <= rtc_pkg::BS_ADDR; // [RL18]
				cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end else if (bus_stop) begin
				// Stop: release and idle
				st_q <= rtc_pkg::BS_IDLE; // [RL17]
				sda_oe_q <= 1'b0;
			end else begin
				unique case (st_q)
					rtc_pkg::BS_IDLE: begin
						// Line left released
						sda_oe_q <= 1'b0; // [RL17]
					end
					rtc_pkg::BS_ADDR, rtc_pkg::BS_PTR, rtc_pkg::BS_WDATA: begin
						if (scl_rise && cnt_q != 4'h8) begin
							// Sample with the clock high
							sh_q <= {sh_q[6:0], sync2_q[0]}; // [RL19]
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == 4'h8) begin
							cnt_q <= 4'h0;
							if (st_q == rtc_pkg::BS_ADDR) begin
								if (sh_q[7:1] == rtc_pkg::SLAVE_ADDR) begin
									// Own address: acknowledge
									sda_oe_q <= 1'b1; // [RL20] [RL22]
									st_q <= rtc_pkg::BS_SACK;
									after_ack_q <= sh_q[0] ? rtc_pkg::BS_RDATA
										: rtc_pkg::BS_PTR; // [RL22]
								end else begin
									// Another device: stay silent
									st_q <= rtc_pkg::BS_IDLE; // [RL20]
								end
							end else begin
								if (st_q == rtc_pkg::BS_PTR) begin
									ptr_q <= sh_q[5:0]; // [RL24]
								end else begin
									ptr_q <= ptr_q + 6'h01; // [RL23]
								end
								sda_oe_q <= 1'b1;
								st_q <= rtc_pkg::BS_SACK;
								after_ack_q <= rtc_pkg::BS_WDATA;
							end
						end
					end
					rtc_pkg::BS_SACK: begin
						if (scl_fall) begin
							if (after_ack_q == rtc_pkg::BS_RDATA) begin
								// Load the next byte and put its top bit out
								sh_q <= {rd_byte[6:0], 1'b0};
								sda_oe_q <= ~rd_byte[7]; // [RL19] [RL21]
								cnt_q <= 4'h1;
								ptr_q <= ptr_q + 6'h01; // [RL23]
							end else begin
								sda_oe_q <= 1'b0;
							end
							st_q <= after_ack_q;
						end
					end
					rtc_pkg::BS_RDATA: begin
						if (scl_fall) begin
							if (cnt_q == 4'h8) begin
								// Release for the master's answer
								sda_oe_q <= 1'b0;
								st_q <= rtc_pkg::BS_MACK;
							end else begin
								sda_oe_q <= ~sh_q[7]; // [RL19] [RL21]
								sh_q <= {sh_q[6:0], 1'b0};
								cnt_q <= cnt_q + 4'h1;
							end
						end
					end
					rtc_pkg::BS_MACK: begin
						if (scl_rise) begin
							// Low continues the read, high ends it
							st_q <= sync2_q[0] ? rtc_pkg::BS_IDLE : rtc_pkg::BS_SACK;
							after_ack_q <= rtc_pkg::BS_RDATA;
						end
					end
					default: begin
						st_q <= rtc_pkg::BS_IDLE;
						sda_oe_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Open-drain data: only ever pulled low
	assign sda_o = 1'b0; // [RL21]
	assign sda_oe = sda_oe_q; // [RL21]

	// Checks on the logic above
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	// A second that ends a minute
	sequence sec_wrap_s;
		clk_en && tick && tm_q.sec == 7'h59 && !wr_en;
	endsequence
	// A write that clears the stop flag
	sequence osf_clear_s;
		clk_en && wr_en && ptr_q == rtc_pkg::REG_CTL && !sh_q[rtc_pkg::BIT_OSF];
	endsequence

	static_level_a: assert property (clk_en && !ctl_q.square_wave_enable |=> wave_output_pin == $past(ctl_q.out)) // [RL1]
		else $error("static output level wrong");
	wave_follow_a: assert property (clk_en && ctl_q.square_wave_enable && ctl_q.rs == rtc_pkg::RATE_4K
		|=> wave_output_pin == $past(div_q[rtc_pkg::TAP_4K])) // [RL2]
		else $error("square wave not on pin");
	tick_fall_a: assert property (tick |-> div_q[rtc_pkg::TAP_1HZ] && clk_en ##1 !div_q[rtc_pkg::TAP_1HZ]) // [RL4]
		else $error("tick not at 1 Hz falling edge");
	osf_set_a: assert property (clk_en && tm_q.oscillator_disable |=> ctl_q.oscillator_stop_flag) // [RL5]
		else $error("stop flag not set");
	osf_hold_a: assert property (clk_en && ctl_q.oscillator_stop_flag && !(wr_en && ptr_q == rtc_pkg::REG_CTL) |=> ctl_q.oscillator_stop_flag) // [RL6]
		else $error("stop flag lost");
	osf_clear_a: assert property (osf_clear_s ##0 !tm_q.oscillator_disable && !osc_stopped |=> !ctl_q.oscillator_stop_flag) // [RL6]
		else $error("stop flag not cleared");
	sec_wrap_a: assert property (sec_wrap_s |=> tm_q.sec == 7'h00 && tm_q.min != $past(tm_q.min)) // [RL7] [RL8]
		else $error("seconds did not carry");
	no_tick_a: assert property (tm_q.oscillator_disable |-> !tick) // [RL25]
		else $error("tick while oscillator stopped");
	ptr_step_a: assert property (wr_en && clk_en |=> ptr_q == $past(ptr_q) + 6'h01) // [RL23]
		else $error("pointer did not advance");
	start_addr_a: assert property (clk_en && bus_start |=> st_q == rtc_pkg::BS_ADDR && !sda_oe) // [RL18]
		else $error("start not taken");
	foreign_addr_a: assert property (clk_en && st_q == rtc_pkg::BS_ADDR && scl_fall && cnt_q == 4'h8
		&& sh_q[7:1] != rtc_pkg::SLAVE_ADDR && !bus_start && !bus_stop
		|=> st_q == rtc_pkg::BS_IDLE ##1 !sda_oe) // [RL20]
		else $error("answered foreign address");
endmodule : rtc_core

/* File: tb/rtc_bus_mst.sv */
// Behavioural two-wire bus master that drives the clock core's bus pins.
`timescale 1ns/1ps
module rtc_bus_mst (
	// Open-drain lines: clock released high, data pulled low when set
	output logic scl,
	output logic sda_low,
	// Wired data level
	input wire logic sda
);
	// Bus idle: both lines released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// One bit out: data moves only while the clock is low
	task automatic bit_out(input logic b);
		sda_low = !b;
		#40 scl = 1'b1;
		#80 scl = 1'b0;
		#40;
	endtask : bit_out
	// One bit in: line released, sampled late in the clock high phase
	task automatic bit_in(output logic b);
		sda_low = 1'b0;
		#40 scl = 1'b1;
		#80 b = sda;
		scl = 1'b0;
		#40;
	endtask : bit_in
	// Start or repeated start: data falls while the clock is high
	task automatic start();
		sda_low = 1'b0;
		#40 scl = 1'b1;
		#80 sda_low = 1'b1;
		#80 scl = 1'b0;
		#40;
	endtask : start
	// Stop: data rises while the clock is high, then both lines stay released
	task automatic stop();
		sda_low = 1'b1;
		#40 scl = 1'b1;
		#80 sda_low = 1'b0;
		#80;
	endtask : stop
	// Byte out MSB first, then the ninth clock carries the answer
	task automatic send(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(b);
		ack = !b;
	endtask : send
	// Byte in MSB first; high answer ends a read
	task automatic recv(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(last);
	endtask : recv
endmodule : rtc_bus_mst

/* File: tb/tb.sv */
// Self-checking bench for the clock/calendar core and its bus slave.
`timescale 1ns/1ps
module tb;
	// Clock, reset, oscillator and pins
	logic core_clk, arst_n, osc_in, osc_run, sda_o, sda_oe, wave_output_pin, scl, sda_low;
	wire sda;
	int n_errors, n_compared;
	logic [7:0] dat [0:7]; // Bytes of one transfer
	logic [7:0] cnt; // Wave rises seen
	logic prev, a;
	logic [39:0] masks;
	// Ordinary case: control byte, read-back, rises in 64 cycles, static level
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] rb;
		logic [7:0] rises;
		logic lvl;
	} rtc_row_t;
	rtc_row_t rows [0:5];
	// Wired-AND data line with pull-up
	assign sda = !(sda_low || sda_oe);
	rtc_core #(.OSC_STOP_CYC(40)) u_dut (
		.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .osc_in(osc_in),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.wave_output_pin(wave_output_pin)
	);
	rtc_bus_mst u_mst (.scl(scl), .sda_low(sda_low), .sda(sda));
	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Fast oscillator, one edge a cycle, so a second lasts 65536 cycles
	always @(posedge core_clk) if (osc_run) osc_in <= #1 ~osc_in;
	// Verdict and end of run
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// Compare one byte and count it
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : chk
	// Write n bytes of dat from pointer p
	task automatic wr(input logic [7:0] p, input int n);
		@(posedge core_clk);
		#1 u_mst.start();
		u_mst.send(8'hd0, a);
		chk("addr ack", 8'h01, {7'h00, a});
		u_mst.send(p, a);
		for (int i = 0; i < n; i++) begin
			u_mst.send(dat[i], a);
			chk("data ack", 8'h01, {7'h00, a});
		end
		u_mst.stop();
	endtask : wr
	// Read n bytes into dat from pointer p, through a repeated start
	task automatic rd(input logic [7:0] p, input int n);
		@(posedge core_clk);
		#1 u_mst.start();
		u_mst.send(8'hd0, a);
		u_mst.send(p, a);
		u_mst.start();
		u_mst.send(8'hd1, a);
		chk("read ack", 8'h01, {7'h00, a});
		for (int i = 0; i < n; i++) u_mst.recv(dat[i], i == n - 1);
		u_mst.stop();
	endtask : rd
	// Wait, bounded, for the wave pin to reach a level
	task automatic wait_pin(input logic v);
		int k;
		k = 0;
		while (wave_output_pin !== v && k < 70000) begin
			@(posedge core_clk);
			k++;
		end
		chk("wave level", {7'h00, v}, {7'h00, wave_output_pin});
	endtask : wait_pin
	// Preset the time with a 1 Hz wave, then read it after the wave falls
	task automatic tick_case(input string what, input logic [55:0] p, input logic [55:0] e);
		dat[0] = p[39:32] & 8'h40;
		wr(8'h02, 1);
		for (int i = 0; i < 7; i++) dat[i] = p[55-8*i -: 8];
		dat[7] = 8'h10;
		wr(8'h00, 8);
		wait_pin(1'b1);
		rd(8'h00, 1);
		chk("seconds before fall", p[55:48], dat[0]);
		wait_pin(1'b0);
		repeat (8) @(posedge core_clk);
		rd(8'h00, 7);
		for (int i = 0; i < 7; i++) chk(what, e[55-8*i -: 8], dat[i]);
		$display("test %s done", what);
	endtask : tick_case
	// Main sequence
	initial begin
		arst_n = 1'b0;
		osc_in = 1'b0;
		osc_run = 1'b0;
		n_errors = 0;
		n_compared = 0;
		rows = '{'{8'h13, 8'h13, 8'd32, 1'b0}, '{8'h12, 8'h12, 8'd8, 1'b0},
			'{8'h11, 8'h11, 8'd4, 1'b0}, '{8'h80, 8'h80, 8'd0, 1'b1},
			'{8'h4c, 8'h00, 8'd0, 1'b0}, '{8'hcf, 8'h83, 8'd0, 1'b1}};
		repeat (5) @(posedge core_clk);
		#1 chk("pin in reset", 8'h01, {7'h00, wave_output_pin});
		chk("oe in reset", 8'h00, {7'h00, sda_oe});
		repeat (5) @(posedge core_clk);
		#1 arst_n = 1'b1;
		osc_run = 1'b1;
		repeat (5) @(posedge core_clk);
		rd(8'h07, 1);
		chk("ctl default", 8'hb3, dat[0]);
		dat[0] = 8'h03;
		wr(8'h07, 1);
		dat[0] = 8'h23;
		wr(8'h07, 1);
		rd(8'h07, 1);
		chk("stop flag", 8'h03, dat[0]);
		$display("test reset and flag done");
		// Output modes and rates
		foreach (rows[r]) begin
			dat[0] = rows[r].ctl;
			wr(8'h07, 1);
			rd(8'h07, 1);
			chk("ctl readback", rows[r].rb, dat[0]);
			cnt = 0;
			@(negedge core_clk);
			prev = wave_output_pin;
			repeat (64) begin
				@(negedge core_clk);
				if (wave_output_pin && !prev) cnt++;
				prev = wave_output_pin;
			end
			chk("wave rises", rows[r].rises, cnt);
			if (rows[r].rises == 0) chk("static", {7'h00, rows[r].lvl}, {7'h00, wave_output_pin});
			$display("test row %0d done", r);
		end
		// Six-bit pointer, auto increment and fixed-zero bits
		foreach (dat[i]) dat[i] = 8'hff;
		wr(8'h41, 5);
		rd(8'h01, 5);
		masks = 40'h7f7f073f1f;
		for (int i = 0; i < 5; i++) chk("fixed zeros", masks[39-8*i -: 8], dat[i]);
		// Foreign address gets no answer
		@(posedge core_clk);
		#1 u_mst.start();
		u_mst.send(8'ha0, a);
		u_mst.stop();
		chk("foreign ack", 8'h00, {7'h00, a});
		chk("bus idle", 8'h01, {7'h00, sda});
		$display("test bus done");
		tick_case("24h", 56'h59592307280203, 56'h00000001010303);
		tick_case("12h", 56'h59597103280204, 56'h00005204290204);
		// Stop flag from oscillator disable and from a silent oscillator
		dat[0] = 8'h80;
		wr(8'h00, 1);
		repeat (50) @(posedge core_clk);
		rd(8'h07, 1);
		chk("flag on disable", 8'h30, dat[0]);
		dat[0] = 8'h00;
		wr(8'h00, 1);
		dat[0] = 8'h10;
		wr(8'h07, 1);
		osc_run = 1'b0;
		repeat (100) @(posedge core_clk);
		rd(8'h07, 1);
		chk("flag on stop", 8'h30, dat[0]);
		$display("test oscillator stop done");
		wrap_up();
	end
	// Watchdog: two simulated seconds end near 1.32 ms
	initial begin
		#1500000;
		n_errors++;
		$display("[FAIL] watchdog expected finish seen timeout");
		wrap_up();
	end
endmodule : tb
